// *** hw/axis_marks_regs.vh ***
`ifndef AXIS_MARKS_REGS_VH
`define AXIS_MARKS_REGS_VH

`define REG_CTRL 8'h00
`define REG_ERR 8'h01
`define REG_FAST 8'h02
`define REG_SLOW 8'h03
`define REG_JOG 8'h04
`define REG_OVR 8'h05
`define REG_DWELL 8'h06
`define REG_LUBE 8'h07
`define REG_MINACK 8'h08
`define REG_GEAR 8'h09
`define REG_HOME 8'h0A
`define GRP_TGT 6'h04
`define GRP_CMD 6'h05
`define GRP_FERR 6'h06
`define GRP_SLO 6'h07
`define GRP_SHI 6'h08

`define CTRL_JOG 0
`define CTRL_HOME 1
`define CTRL_RUN 2
`define CTRL_GANTRY 3
`define CTRL_VALID 4
`define ERR_OT 0
`define ERR_LOOP 1
`define ERR_LOCK 2

`define RST_FAST 16'h0400
`define RST_SLOW 16'h0080
`define RST_JOG 16'h0200
`define RST_OVR 8'h64
`define RST_DWELL 16'h0010
`define RST_LUBE 16'h1000
`define RST_MINACK 16'h0004
`define PCT_DIV 24'h00_0064
`define GEAR_CODE_BASE 8'h28
`define GANTRY_SLAVE 1

`endif

// *** hw/scan_sampler.v ***
`timescale 1ns/1ps
module scan_sampler #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Raw marks from the PLC
    input wire tick_i,
    input wire [W-1:0] raw_i,
    // Scan samples and edges
    output reg [W-1:0] cur_o,
    output reg [W-1:0] rise_o,
    output reg [W-1:0] fall_o
);
    reg [W-1:0] m1_q;
    reg [W-1:0] m2_q;
    reg t1_q;
    reg t2_q;
    reg t3_q;

    always @(posedge clk_i) begin
        if (reset_i) begin
            m1_q <= {W{1'b0}};
            m2_q <= {W{1'b0}};
            t1_q <= 1'b0;
            t2_q <= 1'b0;
            t3_q <= 1'b0;
            cur_o <= {W{1'b0}};
            rise_o <= {W{1'b0}};
            fall_o <= {W{1'b0}};
        end else begin
            m1_q <= raw_i;
            m2_q <= m1_q;
            t1_q <= tick_i;
            t2_q <= t1_q;
            t3_q <= t2_q;
            // Edges only between two scan samples, so mid-scan glitches vanish
            if (t2_q && !t3_q) begin
                cur_o <= m2_q;
                rise_o <= m2_q & ~cur_o;
                fall_o <= ~m2_q & cur_o;
            end else begin
                rise_o <= {W{1'b0}};
                fall_o <= {W{1'b0}};
            end
        end
    end
endmodule // scan_sampler

// *** hw/axis_marks.v ***
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "axis_marks_regs.vh"
module axis_marks (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [15:0] wdata_i,
    input wire write_i,
    input wire read_i,
    output reg [15:0] rdata_o,
    // PLC scan tick and marks, bit n for axis n; aux_done_ack_i is one shared bit
    input wire scan_tick_i,
    input wire [3:0] positive_overtravel_flag_i,
    input wire [3:0] negative_overtravel_flag_i,
    input wire [3:0] home_switch_slowdown_i,
    input wire [3:0] motion_inhibit_i,
    input wire [3:0] jog_plus_request_i,
    input wire [3:0] jog_minus_request_i,
    input wire [3:0] loop_closed_flag_i,
    input wire [3:0] readout_only_i,
    input wire [3:0] speed_permit_i,
    input wire [3:0] power_stage_permit_i,
    input wire [3:0] soft_limit_override_i,
    input wire [3:0] lube_feature_on_i,
    input wire [3:0] lube_done_ack_i,
    input wire [3:0] gantry_offset_correct_i,
    input wire [3:0] range_selected_i,
    input wire aux_done_ack_i,
    // Measured positions, axis 0 in low bits
    input wire [63:0] meas_pos_i,
    // Motion answers
    output reg [3:0] motion_request_o,
    output reg [3:0] lube_request_o,
    output reg [63:0] servo_cmd_o,
    output reg stop_all_o,
    // Drive link
    output reg drive_msg_valid_o,
    output reg [1:0] drive_msg_axis_o,
    output reg [1:0] drive_msg_bits_o,
    // Gear change handshake
    output reg [7:0] misc_function_code_o,
    output reg misc_function_strobe_o
);
    localparam G_IDLE = 2'b00;
    localparam G_WLOW = 2'b01;
    localparam G_WHIGH = 2'b10;
    localparam G_HOLD = 2'b11;

    wire [60:0] mk;
    wire [60:0] mk_rise;
    wire [60:0] mk_fall;

    scan_sampler #(.W(61)) u_sampler (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tick_i(scan_tick_i),
        .raw_i({aux_done_ack_i, range_selected_i, gantry_offset_correct_i, lube_done_ack_i,
                lube_feature_on_i, soft_limit_override_i, power_stage_permit_i, speed_permit_i,
                readout_only_i, loop_closed_flag_i, jog_minus_request_i, jog_plus_request_i,
                motion_inhibit_i, home_switch_slowdown_i, negative_overtravel_flag_i,
                positive_overtravel_flag_i}),
        .cur_o(mk),
        .rise_o(mk_rise),
        .fall_o(mk_fall)
    );

    wire [3:0] ot_p = mk[3:0];
    wire [3:0] ot_n = mk[7:4];
    wire [3:0] slowdn = mk[11:8];
    wire [3:0] inhib = mk[15:12];
    wire [3:0] jp = mk[19:16];
    wire [3:0] jn = mk[23:20];
    wire [3:0] loop = mk[27:24];
    wire [3:0] ro_mk = mk[31:28];
    wire [3:0] spd_pm = mk[35:32];
    wire [3:0] pwr_pm = mk[39:36];
    wire [3:0] soft_ov = mk[43:40];
    wire [3:0] lube_on = mk[47:44];
    wire [3:0] gmark = mk[55:52];
    wire [3:0] range_s = mk[59:56];
    wire aux_ack = mk[60];

    reg [63:0] meas_m_q;
    reg [63:0] meas_s_q;
    reg [4:0] ctrl_q;
    reg [2:0] err_q;
    reg [15:0] fast_q;
    reg [15:0] slow_q;
    reg [15:0] jog_q;
    reg [7:0] ovr_q;
    reg [15:0] dwell_q;
    reg [15:0] lube_dist_q;
    reg [15:0] minack_q;
    reg gantry_q;
    reg [3:0] pend_q;
    reg [1:0] gst_q;
    reg [15:0] ack_cnt_q;

    wire [63:0] tgt_f;
    wire [63:0] cmd_f;
    wire [63:0] ferr_f;
    wire [63:0] slo_f;
    wire [63:0] shi_f;
    wire [3:0] req_f;
    wire [3:0] lube_f;
    wire [3:0] home_f;
    wire [3:0] ot_ev;
    wire [3:0] drop_ev;
    wire [3:0] lock_ev;

    wire halt = |err_q;
    wire validate = write_i && addr_i == `REG_CTRL && wdata_i[`CTRL_VALID];
    wire [23:0] jog_prod = jog_q * ovr_q;
    wire [23:0] jog_div = jog_prod / `PCT_DIV;
    wire [15:0] jog_spd = jog_div[15:0];
    // Interpolating axes share one program, so any inhibit holds them all
    wire prog_hold = ctrl_q[`CTRL_RUN] & |inhib;
    wire [15:0] mcmd = cmd_f[15:0];

    always @(posedge clk_i) begin
        meas_m_q <= meas_pos_i;
        meas_s_q <= meas_m_q;
    end

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_axis
            localparam [1:0] IX = i;
            reg [15:0] cmd_q;
            reg [15:0] tgt_q;
            reg [15:0] acc_q;
            reg [15:0] slo_q;
            reg [15:0] shi_q;
            reg [15:0] dw_cnt_q;
            reg [15:0] lube_cnt_q;
            reg req_q;
            reg checked_q;
            reg lube_q;
            reg seen_q;
            reg done_q;
            wire [15:0] meas = meas_s_q[16*i +: 16];
            wire ro = ro_mk[i] & ~loop[i];
            wire lim = ~soft_ov[i];
            wire [15:0] tgt_e = !lim ? tgt_q : (tgt_q < slo_q) ? slo_q : (tgt_q > shi_q) ? shi_q : tgt_q;
            // Recovery jog survives an overtravel-only stop; of other motion only gantry correction runs on
            wire ot_only = ~err_q[`ERR_LOOP] & ~err_q[`ERR_LOCK];
            wire jog_p = ctrl_q[`CTRL_JOG] & jp[i] & ~ot_p[i] & (~halt | (ot_only & ot_n[i]))
                         & ~(lim & cmd_q >= shi_q);
            wire jog_n = ctrl_q[`CTRL_JOG] & jn[i] & ~ot_n[i] & ~jp[i] & (~halt | (ot_only & ot_p[i]))
                         & ~(lim & cmd_q <= slo_q);
            wire home = ctrl_q[`CTRL_HOME] & ~done_q & ~halt;
            wire gant = (i == `GANTRY_SLAVE) & gantry_q;
            wire prog = ctrl_q[`CTRL_RUN] & ~prog_hold & ~halt & ~ro & (cmd_q != tgt_e);
            wire need = gant ? (mcmd != cmd_q) : (home | jog_p | jog_n | prog);
            wire up = gant ? (mcmd > cmd_q) : (home | jog_p | (prog & (tgt_e > cmd_q)));
            wire [15:0] spd = (gant | (home & seen_q)) ? slow_q : home ? fast_q :
                              (jog_p | jog_n) ? jog_spd : fast_q;
            // Gantry correction ignores inhibit; only an open loop or reset stops it
            wire hold = inhib[i] & ~gant;
            wire [16:0] acc_sum = {1'b0, acc_q} + {1'b0, spd};
            // No steps while the loop is open: the axis is locked
            wire run_ok = need & ~hold & loop[i];
            wire step = run_ok & acc_sum[16];

            always @(posedge clk_i) begin
                if (reset_i) begin
                    cmd_q <= 16'h0000;
                    tgt_q <= 16'h0000;
                    acc_q <= 16'h0000;
                    dw_cnt_q <= 16'h0000;
                    lube_cnt_q <= 16'h0000;
                    req_q <= 1'b0;
                    checked_q <= 1'b0;
                    lube_q <= 1'b0;
                    seen_q <= 1'b0;
                    done_q <= 1'b0;
                end else begin
                    if (write_i && addr_i == {`GRP_TGT, IX}) begin
                        tgt_q <= wdata_i;
                    end
                    // Step accumulator restarts from zero whenever run_ok drops
                    acc_q <= run_ok ? acc_sum[15:0] : 16'h0000;
                    if (mk_fall[28 + i]) begin
                        cmd_q <= meas;
                    end else if (ro_mk[i] && ctrl_q[`CTRL_RUN] && !loop[i]) begin
                        cmd_q <= tgt_e;
                    end else if (home && seen_q && mk_fall[8 + i]) begin
                        cmd_q <= 16'h0000;
                    end else if (step) begin
                        cmd_q <= up ? cmd_q + 16'h0001 : cmd_q - 16'h0001;
                    end
                    if (!ctrl_q[`CTRL_HOME]) begin
                        seen_q <= 1'b0;
                        done_q <= 1'b0;
                    end else if (home && mk_rise[8 + i]) begin
                        seen_q <= 1'b1;
                    end else if (home && seen_q && mk_fall[8 + i]) begin
                        done_q <= 1'b1;
                    end
                    req_q <= need & ~hold & ~ro;
                    if (!req_q) begin
                        dw_cnt_q <= 16'h0000;
                        checked_q <= 1'b0;
                    end else if (!checked_q) begin
                        dw_cnt_q <= dw_cnt_q + 16'h0001;
                        if (dw_cnt_q == dwell_q) begin
                            checked_q <= 1'b1;
                        end
                    end
                    if (!lube_on[i] || mk_rise[48 + i]) begin
                        lube_cnt_q <= 16'h0000;
                        lube_q <= 1'b0;
                    end else begin
                        if (step && !lube_q) begin
                            lube_cnt_q <= lube_cnt_q + 16'h0001;
                        end
                        if (lube_cnt_q >= lube_dist_q) begin
                            lube_q <= 1'b1;
                        end
                    end
                end
            end

            // Limits outlive reset; validation or power-off clears them
            always @(posedge clk_i) begin
                if (validate) begin
                    slo_q <= 16'h0000;
                    shi_q <= 16'hFFFF;
                end else if (write_i && addr_i == {`GRP_SLO, IX}) begin
                    slo_q <= wdata_i;
                end else if (write_i && addr_i == {`GRP_SHI, IX}) begin
                    shi_q <= wdata_i;
                end
            end

            assign ot_ev[i] = ot_p[i] | ot_n[i];
            assign drop_ev[i] = mk_fall[24 + i] & req_q & ~ro_mk[i];
            assign lock_ev[i] = req_q & ~checked_q & (dw_cnt_q == dwell_q) & ~loop[i] & ~ro;
            assign tgt_f[16*i +: 16] = tgt_q;
            assign cmd_f[16*i +: 16] = cmd_q;
            assign ferr_f[16*i +: 16] = ro ? 16'h0000 : cmd_q - meas;
            assign slo_f[16*i +: 16] = slo_q;
            assign shi_f[16*i +: 16] = shi_q;
            assign req_f[i] = req_q;
            assign lube_f[i] = lube_q;
            assign home_f[i] = done_q;
        end
    endgenerate

    wire [2:0] err_set = {|lock_ev, |drop_ev, |ot_ev};
    wire [2:0] err_clr = (write_i && addr_i == `REG_ERR) ? wdata_i[2:0] : 3'b000;
    // A new event in the clearing cycle keeps its flag
    wire [2:0] err_d = (err_q & ~err_clr) | err_set;
    wire gstart = ctrl_q[`CTRL_GANTRY] & ((mk_rise[24 + `GANTRY_SLAVE] & gmark[`GANTRY_SLAVE]) |
                  (mk_rise[52 + `GANTRY_SLAVE] & loop[`GANTRY_SLAVE]));
    wire [3:0] chg = mk_rise[35:32] | mk_fall[35:32] | mk_rise[39:36] | mk_fall[39:36];
    reg [3:0] sent;
    reg [1:0] sent_ax;
    integer k;

    always @* begin
        sent = 4'h0;
        sent_ax = 2'b00;
        for (k = 3; k >= 0; k = k - 1) begin
            if (pend_q[k]) begin
                sent = 4'h1 << k;
                sent_ax = k[1:0];
            end
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_q <= 5'h00;
            err_q <= 3'b000;
            fast_q <= `RST_FAST;
            slow_q <= `RST_SLOW;
            jog_q <= `RST_JOG;
            ovr_q <= `RST_OVR;
            dwell_q <= `RST_DWELL;
            lube_dist_q <= `RST_LUBE;
            minack_q <= `RST_MINACK;
            gantry_q <= 1'b0;
            pend_q <= 4'h0;
            stop_all_o <= 1'b0;
            drive_msg_valid_o <= 1'b0;
            drive_msg_axis_o <= 2'b00;
            drive_msg_bits_o <= 2'b00;
        end else begin
            if (write_i) begin
                if (addr_i == `REG_CTRL) begin
                    ctrl_q <= {1'b0, wdata_i[3:0]};
                end else if (addr_i == `REG_FAST) begin
                    fast_q <= wdata_i;
                end else if (addr_i == `REG_SLOW) begin
                    slow_q <= wdata_i;
                end else if (addr_i == `REG_JOG) begin
                    jog_q <= wdata_i;
                end else if (addr_i == `REG_OVR) begin
                    ovr_q <= wdata_i[7:0];
                end else if (addr_i == `REG_DWELL) begin
                    dwell_q <= wdata_i;
                end else if (addr_i == `REG_LUBE) begin
                    lube_dist_q <= wdata_i;
                end else if (addr_i == `REG_MINACK) begin
                    minack_q <= wdata_i;
                end
            end
            err_q <= err_d;
            stop_all_o <= |err_d;
            if (gstart) begin
                gantry_q <= 1'b1;
            end else if (gantry_q && mcmd == cmd_f[16*`GANTRY_SLAVE +: 16]) begin
                gantry_q <= 1'b0;
            end
            pend_q <= (pend_q & ~sent) | chg;
            drive_msg_valid_o <= |pend_q;
            drive_msg_axis_o <= sent_ax;
            drive_msg_bits_o <= {pwr_pm[sent_ax], spd_pm[sent_ax]};
        end
    end

    // Gear change: strobe waits for the acknowledge to fall, rise and stay
    always @(posedge clk_i) begin
        if (reset_i) begin
            gst_q <= G_IDLE;
            ack_cnt_q <= 16'h0000;
            misc_function_code_o <= 8'h00;
            misc_function_strobe_o <= 1'b0;
        end else begin
            case (gst_q)
                G_IDLE: begin
                    if (write_i && addr_i == `REG_GEAR && wdata_i[2:0] >= 3'h1 && wdata_i[2:0] <= 3'h4) begin
                        misc_function_code_o <= `GEAR_CODE_BASE + {5'h00, wdata_i[2:0]};
                        misc_function_strobe_o <= 1'b1;
                        gst_q <= G_WLOW;
                    end
                end
                G_WLOW: begin
                    if (!aux_ack) begin
                        gst_q <= G_WHIGH;
                    end
                end
                G_WHIGH: begin
                    ack_cnt_q <= 16'h0000;
                    if (aux_ack) begin
                        gst_q <= G_HOLD;
                    end
                end
                G_HOLD: begin
                    if (!aux_ack) begin
                        gst_q <= G_WHIGH;
                    end else if (ack_cnt_q > minack_q) begin
                        misc_function_strobe_o <= 1'b0;
                        misc_function_code_o <= 8'h00;
                        gst_q <= G_IDLE;
                    end else begin
                        ack_cnt_q <= ack_cnt_q + 16'h0001;
                    end
                end
                default: begin
                    gst_q <= G_IDLE;
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            motion_request_o <= 4'h0;
            lube_request_o <= 4'h0;
            servo_cmd_o <= 64'h0000_0000_0000_0000;
            rdata_o <= 16'h0000;
        end else begin
            motion_request_o <= req_f;
            lube_request_o <= lube_f;
            servo_cmd_o <= cmd_f;
            rdata_o <= 16'h0000;
            if (read_i) begin
                if (addr_i == `REG_CTRL) begin
                    rdata_o <= {11'h000, ctrl_q};
                end else if (addr_i == `REG_ERR) begin
                    rdata_o <= {9'h000, req_f, err_q};
                end else if (addr_i == `REG_FAST) begin
                    rdata_o <= fast_q;
                end else if (addr_i == `REG_SLOW) begin
                    rdata_o <= slow_q;
                end else if (addr_i == `REG_JOG) begin
                    rdata_o <= jog_q;
                end else if (addr_i == `REG_OVR) begin
                    rdata_o <= {8'h00, ovr_q};
                end else if (addr_i == `REG_DWELL) begin
                    rdata_o <= dwell_q;
                end else if (addr_i == `REG_LUBE) begin
                    rdata_o <= lube_dist_q;
                end else if (addr_i == `REG_MINACK) begin
                    rdata_o <= minack_q;
                end else if (addr_i == `REG_GEAR) begin
                    rdata_o <= {7'h00, gantry_q, misc_function_strobe_o, 3'b000, range_s};
                end else if (addr_i == `REG_HOME) begin
                    rdata_o <= {12'h000, home_f};
                end else if (addr_i[7:2] == `GRP_TGT) begin
                    rdata_o <= tgt_f[{addr_i[1:0], 4'h0} +: 16];
                end else if (addr_i[7:2] == `GRP_CMD) begin
                    rdata_o <= cmd_f[{addr_i[1:0], 4'h0} +: 16];
                end else if (addr_i[7:2] == `GRP_FERR) begin
                    rdata_o <= ferr_f[{addr_i[1:0], 4'h0} +: 16];
                end else if (addr_i[7:2] == `GRP_SLO) begin
                    rdata_o <= slo_f[{addr_i[1:0], 4'h0} +: 16];
                end else if (addr_i[7:2] == `GRP_SHI) begin
                    rdata_o <= shi_f[{addr_i[1:0], 4'h0} +: 16];
                end
            end
        end
    end
endmodule // axis_marks

// *** verif/axis_marks_assertions.sv ***
`timescale 1ns/1ps
module axis_marks_assertions (
    // Clock and reset
    input wire clk_i,
    input wire reset_i,
    // Watched ports
    input wire [7:0] addr_i,
    input wire write_i,
    input wire read_i,
    input wire [15:0] rdata_o,
    input wire [3:0] speed_permit_i,
    input wire [3:0] power_stage_permit_i,
    input wire aux_done_ack_i,
    input wire [3:0] motion_request_o,
    input wire stop_all_o,
    input wire drive_msg_valid_o,
    input wire [1:0] drive_msg_axis_o,
    input wire [1:0] drive_msg_bits_o,
    input wire [7:0] misc_function_code_o,
    input wire misc_function_strobe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire err_wr = write_i && addr_i == 8'h01;
    sequence strobe_stands;
        misc_function_strobe_o [*5];
    endsequence
    AST_RDATA_IDLE: assert property (!$past(read_i) |-> rdata_o == 16'h0000) else $error("rdata without read");
    AST_OUT_RESET: assert property ($past(reset_i) |-> !stop_all_o && motion_request_o == 4'h0
        && !misc_function_strobe_o && !drive_msg_valid_o) else $error("output set after reset");
    AST_GEAR_START: assert property ($rose(misc_function_strobe_o) |-> $past(write_i && addr_i == 8'h09))
        else $error("strobe without gear write");
    AST_GEAR_CODE: assert property (misc_function_strobe_o |-> misc_function_code_o >= 8'h29
        && misc_function_code_o <= 8'h2C) else $error("gear code out of range");
    AST_GEAR_IDLE: assert property (!misc_function_strobe_o |-> misc_function_code_o == 8'h00)
        else $error("code without strobe");
    AST_GEAR_STABLE: assert property (misc_function_strobe_o |=> !misc_function_strobe_o
        || $stable(misc_function_code_o)) else $error("code moved under strobe");
    AST_ACK_HOLD: assert property (misc_function_strobe_o && !aux_done_ack_i |=> strobe_stands)
        else $error("strobe dropped too early");
    AST_OT_CLEAR: assert property ($fell(stop_all_o) |-> $past(err_wr) || $past(err_wr, 2)
        || $past(err_wr, 3)) else $error("stop cleared without error clear");
    AST_DRV_BITS: assert property (drive_msg_valid_o |-> drive_msg_bits_o ==
        {power_stage_permit_i[drive_msg_axis_o], speed_permit_i[drive_msg_axis_o]})
        else $error("drive message level wrong");
endmodule // axis_marks_assertions
bind axis_marks axis_marks_assertions u_axis_marks_assertions (.*);

// *** verif/plc_scan_model.sv ***
`timescale 1ns/1ps
module plc_scan_model (
    // Clock
    input wire clk_i,
    // Gear handshake and scan tick
    input wire misc_function_strobe_i,
    output reg scan_tick_o = 1'b0,
    output reg aux_done_ack_o = 1'b1
);
    reg [2:0] cnt_q = 3'h0;
    reg [3:0] scans_q = 4'h0;
    always @(posedge clk_i) begin
        cnt_q <= cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
            scan_tick_o <= ~scan_tick_o;
            if (!misc_function_strobe_i) begin
                scans_q <= 4'h0;
            end else if (scans_q != 4'hF) begin
                scans_q <= scans_q + 4'h1;
            end
        end
        // Low over two full scans so the drop is sampled, then held high
        aux_done_ack_o <= !(misc_function_strobe_i && scans_q < 4'h4);
    end
endmodule // plc_scan_model

// *** verif/axis_marks_tb_top.sv ***
`timescale 1ns/1ps
module axis_marks_tb_top;
    reg clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg [7:0] addr_i = 8'h00;
    reg [15:0] wdata_i = 16'h0000;
    reg write_i = 1'b0;
    reg read_i = 1'b0;
    reg [3:0] ot_pos = 4'h0, jog_p = 4'h0, loop_c = 4'hF, zero4 = 4'h0;
    reg [3:0] spd = 4'h0, pwr = 4'h0;
    reg [3:0] lube_on = 4'h0, lube_ok = 4'h0;
    wire [3:0] lube_req;
    wire [63:0] servo_cmd;
    reg [3:0] rng = 4'h1;
    reg [111:0] tbl = {16'h0004, 16'h1000, 16'h0010, 16'h0064, 16'h0200, 16'h0080, 16'h0400};
    integer mismatches = 0, tests_run = 0, i;
    reg [15:0] d;
    wire [15:0] rdata_o;
    wire [3:0] motion_request_o;
    wire [7:0] misc_function_code_o;
    wire [1:0] drive_msg_axis_o, drive_msg_bits_o;
    wire stop_all_o, drive_msg_valid_o, misc_function_strobe_o, scan_tick, aux_ack;
    always #50 clk_i = ~clk_i;
    plc_scan_model u_plc_scan_model (.clk_i(clk_i), .misc_function_strobe_i(misc_function_strobe_o),
        .scan_tick_o(scan_tick), .aux_done_ack_o(aux_ack));
    axis_marks u_axis_marks (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .scan_tick_i(scan_tick),
        .positive_overtravel_flag_i(ot_pos), .negative_overtravel_flag_i(zero4), .home_switch_slowdown_i(zero4),
        .motion_inhibit_i(zero4), .jog_plus_request_i(jog_p), .jog_minus_request_i(zero4),
        .loop_closed_flag_i(loop_c), .readout_only_i(zero4), .speed_permit_i(spd), .power_stage_permit_i(pwr),
        .soft_limit_override_i(zero4), .lube_feature_on_i(lube_on), .lube_done_ack_i(lube_ok),
        .gantry_offset_correct_i(zero4), .range_selected_i(rng), .aux_done_ack_i(aux_ack), .meas_pos_i(64'h0),
        .motion_request_o(motion_request_o), .lube_request_o(lube_req), .servo_cmd_o(servo_cmd),
        .stop_all_o(stop_all_o),
        .drive_msg_valid_o(drive_msg_valid_o), .drive_msg_axis_o(drive_msg_axis_o),
        .drive_msg_bits_o(drive_msg_bits_o), .misc_function_code_o(misc_function_code_o),
        .misc_function_strobe_o(misc_function_strobe_o));
    task check(input [15:0] seen, input [15:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("Error %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("mismatches %0d tests_run %0d", mismatches, tests_run);
            if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task guard(input ok);
        if (!ok) begin
            mismatches = mismatches + 1;
            $display("Error %0t: wait ran out", $time);
            test_done;
        end
    endtask
    task wr(input [7:0] a, input [15:0] v);
        begin
            addr_i <= a;
            wdata_i <= v;
            write_i <= 1'b1;
            @(posedge clk_i);
            write_i <= 1'b0;
        end
    endtask
    task rchk(input [7:0] a, input [15:0] exp);
        begin
            addr_i <= a;
            read_i <= 1'b1;
            @(posedge clk_i);
            read_i <= 1'b0;
            @(posedge clk_i);
            check(rdata_o, exp);
        end
    endtask
    task t_regs;
        begin
            wr(8'h00, 16'h0010);
            for (i = 0; i < 7; i = i + 1) rchk(8'h02 + i[7:0], tbl[16*i +: 16]);
            rchk(8'h20, 16'hFFFF);
            rchk(8'hFF, 16'h0000);
            reset_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            reset_i <= 1'b0;
            @(posedge clk_i);
            rchk(8'h20, 16'hFFFF);
        end
    endtask
    task t_ot;
        begin
            ot_pos <= 4'h1;
            for (i = 0; i < 100 && stop_all_o !== 1'b1; i = i + 1) @(posedge clk_i);
            guard(i < 100);
            rchk(8'h01, 16'h0001);
            ot_pos <= 4'h0;
            // Error re-sets while the mark is still sampled high, so keep clearing
            for (i = 0; i < 100 && stop_all_o !== 1'b0; i = i + 1) begin
                wr(8'h01, 16'h0007);
                @(posedge clk_i);
            end
            guard(i < 100);
            rchk(8'h01, 16'h0000);
        end
    endtask
    task t_jog;
        begin
            wr(8'h00, 16'h0001);
            jog_p <= 4'h8;
            for (i = 0; i < 100 && motion_request_o[3] !== 1'b1; i = i + 1) @(posedge clk_i);
            guard(i < 100);
            jog_p <= 4'h0;
            for (i = 0; i < 100 && motion_request_o !== 4'h0; i = i + 1) @(posedge clk_i);
            guard(i < 100);
            check(stop_all_o, 1'b0);
        end
    endtask
    task t_lube;
        begin
            wr(8'h07, 16'h0002);
            lube_on <= 4'h8;
            jog_p <= 4'h8;
            for (i = 0; i < 400 && lube_req[3] !== 1'b1; i = i + 1) @(posedge clk_i);
            guard(i < 400);
            check(lube_req, 4'h8);
            jog_p <= 4'h0;
            for (i = 0; i < 100 && motion_request_o !== 4'h0; i = i + 1) @(posedge clk_i);
            guard(i < 100);
            check(servo_cmd[63:48], 16'h0002);
            lube_ok <= 4'h8;
            for (i = 0; i < 100 && lube_req[3] !== 1'b0; i = i + 1) @(posedge clk_i);
            guard(i < 100);
        end
    endtask
    task t_drive;
        begin
            spd <= 4'h4;
            for (i = 0; i < 100 && drive_msg_valid_o !== 1'b1; i = i + 1) @(posedge clk_i);
            guard(i < 100);
            check({drive_msg_axis_o, drive_msg_bits_o}, 16'h0009);
        end
    endtask
    task t_gear;
        begin
            wr(8'h09, 16'h0003);
            @(posedge clk_i);
            check({misc_function_strobe_o, misc_function_code_o}, 16'h012B);
            for (i = 0; i < 400 && misc_function_strobe_o !== 1'b0; i = i + 1) @(posedge clk_i);
            guard(i < 400);
            check({misc_function_strobe_o, misc_function_code_o}, 16'h0000);
            rchk(8'h09, 16'h0001);
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_regs;
        t_ot;
        t_jog;
        t_lube;
        t_drive;
        t_gear;
        test_done;
    end
endmodule // axis_marks_tb_top
